// File: rtl/prom_programmer.sv
// programmer that drives the prom programming port of the microcontroller
`timescale 1ns/1ps
`default_nettype none
module prom_programmer
    import prom_prog_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYC,
    parameter int TRIES = MAX_TRIES
) (
    input wire logic clk,
    input wire logic sys_rst,
    // user command side
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire op_t cmd_op,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic [PAGE_BYTES*DATA_W-1:0] cmd_data,
    output logic rsp_valid,
    output logic rsp_fail,
    output logic rsp_blank,
    output logic [PAGE_BYTES*DATA_W-1:0] rsp_data,
    output logic [3:0] rsp_tries,
    // device pins
    output logic dev_reset_n,
    output logic vpp_high,
    output logic chip_enable_n,
    output logic output_enable_n,
    output logic program_pulse_n,
    output logic [ADDR_W-1:0] prog_address_bus,
    input wire logic [DATA_W-1:0] prog_data_bus_in,
    output logic [DATA_W-1:0] prog_data_bus_out,
    output logic prog_data_bus_oe_n
);
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_LATCH_SET,
        ST_LATCH_STB,
        ST_ARM,
        ST_PULSE,
        ST_RECOVER,
        ST_VER_SET,
        ST_VER_WAIT,
        ST_READ_WAIT,
        ST_DONE
    } state_t;

    localparam int TIM_W = 16;
    // the timer holds a state one cycle past its load value
    localparam logic [TIM_W-1:0] T_PULSE = TIM_W'(PULSE_CYCLES - 1);
    localparam logic [TIM_W-1:0] T_SETUP = TIM_W'(SETUP_CYC);
    localparam logic [TIM_W-1:0] T_SAMPLE = TIM_W'(SAMPLE_CYC);

    state_t state, next_state;
    op_t op, next_op;
    logic [ADDR_W-1:0] base, next_base;
    logic [PAGE_BYTES*DATA_W-1:0] wdata, next_wdata;
    logic [PAGE_BYTES*DATA_W-1:0] rdata, next_rdata;
    logic [PAGE_IDX_W-1:0] idx, next_idx;
    logic [3:0] tries, next_tries;
    logic busy_pins, next_busy_pins;
    logic ce_n, next_ce_n, oe_n, next_oe_n, pgm_n, next_pgm_n, drive, next_drive;
    logic [ADDR_W-1:0] addr_q, next_addr_q;
    logic [DATA_W-1:0] dout, next_dout;
    logic done_v, next_done_v, fail, next_fail;
    logic tim_load;
    logic [TIM_W-1:0] tim_val;
    logic tim_done;
    logic [DATA_W-1:0] din_meta, din_sync;

    // select one byte lane of a page word
    function automatic logic [DATA_W-1:0] lane(input logic [PAGE_BYTES*DATA_W-1:0] w,
                                               input logic [PAGE_IDX_W-1:0] i);
        lane = w[i*DATA_W +: DATA_W];
    endfunction

    // last byte index of the current operation
    function automatic logic [PAGE_IDX_W-1:0] last_idx(input op_t o);
        last_idx = (o == OP_PAGE) ? PAGE_IDX_W'(PAGE_BYTES - 1) : '0;
    endfunction

    // ---------------------------------------------------------------
    // input synchroniser
    // ---------------------------------------------------------------
    // data pins come from the device, not from our clock domain
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            din_meta <= '0;
            din_sync <= '0;
        end else begin
            din_meta <= prog_data_bus_in;
            din_sync <= din_meta;
        end
    end

    strobe_timer #(.CNT_W(TIM_W)) u_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .load(tim_load),
        .load_val(tim_val),
        .done(tim_done)
    );

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    // one transition per timer expiry keeps pin changes well separated
    always_comb begin
        next_state = state;
        next_op = op;
        next_base = base;
        next_wdata = wdata;
        next_rdata = rdata;
        next_idx = idx;
        next_tries = tries;
        next_busy_pins = busy_pins;
        next_ce_n = ce_n;
        next_oe_n = oe_n;
        next_pgm_n = pgm_n;
        next_drive = drive;
        next_addr_q = addr_q;
        next_dout = dout;
        next_done_v = 1'b0;
        next_fail = fail;
        tim_load = 1'b0;
        tim_val = T_SETUP;
        case (state)
            ST_IDLE: begin
                // standby between commands: ce high floats the device
                next_ce_n = 1'b1;
                next_oe_n = 1'b1;
                next_pgm_n = 1'b1;
                next_drive = 1'b0;
                if (cmd_valid) begin
                    next_op = cmd_op;
                    // pages are aligned; low bits index the byte
                    next_base = (cmd_op == OP_PAGE) ?
                        {cmd_addr[ADDR_W-1:PAGE_IDX_W], {PAGE_IDX_W{1'b0}}} : cmd_addr;
                    next_wdata = cmd_data;
                    next_rdata = '0;
                    next_idx = '0;
                    next_tries = 4'h1;
                    next_fail = 1'b0;
                    next_busy_pins = 1'b1;
                    tim_load = 1'b1;
                    next_state = (cmd_op == OP_READ) ? ST_VER_SET : ST_LATCH_SET;
                end
            end
            ST_LATCH_SET: if (tim_done) begin
                next_addr_q = base | ADDR_W'(idx);
                next_dout = lane(wdata, idx);
                next_drive = 1'b1;
                if (op == OP_PAGE) begin
                    next_ce_n = 1'b1;
                    next_pgm_n = 1'b1;
                    tim_load = 1'b1;
                    next_state = ST_LATCH_STB;
                end else begin
                    next_ce_n = 1'b0;
                    next_oe_n = 1'b1;
                    tim_load = 1'b1;
                    next_state = ST_ARM;
                end
            end
            ST_LATCH_STB: begin
                // oe low with ce high strobes the byte into the page latch
                next_oe_n = 1'b0;
                if (tim_done) begin
                    next_oe_n = 1'b1;
                    tim_load = 1'b1;
                    if (idx == last_idx(op)) begin
                        next_idx = '0;
                        next_state = ST_ARM;
                    end else begin
                        next_idx = idx + PAGE_IDX_W'(1);
                        next_state = ST_LATCH_SET;
                    end
                end
            end
            ST_ARM: if (tim_done) begin
                // address, data and enables settle a gap before the pulse falls
                next_pgm_n = 1'b0;
                next_drive = (op != OP_PAGE);
                tim_load = 1'b1;
                tim_val = T_PULSE;
                next_state = ST_PULSE;
            end
            ST_PULSE: if (tim_done) begin
                // pulse rises alone; in byte mode data and ce are held a gap longer
                next_pgm_n = 1'b1;
                tim_load = 1'b1;
                next_state = ST_RECOVER;
            end
            ST_RECOVER: if (tim_done) begin
                next_drive = 1'b0;
                next_ce_n = 1'b1;
                next_idx = '0;
                tim_load = 1'b1;
                next_state = ST_VER_SET;
            end
            ST_VER_SET: if (tim_done) begin
                next_addr_q = base | ADDR_W'(idx);
                next_ce_n = 1'b0;
                next_oe_n = 1'b0;
                next_pgm_n = 1'b1;
                tim_load = 1'b1;
                tim_val = T_SAMPLE;
                next_state = ST_VER_WAIT;
            end
            ST_VER_WAIT: if (tim_done) begin
                // sample after the synchroniser has caught up
                next_rdata[idx*DATA_W +: DATA_W] = din_sync;
                next_oe_n = 1'b1;
                tim_load = 1'b1;
                if (idx == last_idx(op)) begin
                    next_state = ST_READ_WAIT;
                end else begin
                    next_idx = idx + PAGE_IDX_W'(1);
                    next_state = ST_VER_SET;
                end
            end
            ST_READ_WAIT: begin
                next_ce_n = 1'b1;
                if (op == OP_READ || rdata == wdata ||
                    ((op == OP_BYTE) && (lane(rdata, '0) == lane(wdata, '0)))) begin
                    next_state = ST_DONE;
                end else if (tries >= 4'(TRIES)) begin
                    next_fail = 1'b1;
                    next_state = ST_DONE;
                end else if (tim_done) begin
                    next_tries = tries + 4'h1;
                    next_idx = '0;
                    tim_load = 1'b1;
                    next_state = ST_LATCH_SET;
                end
            end
            ST_DONE: begin
                next_busy_pins = 1'b0;
                next_done_v = 1'b1;
                next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            op <= OP_READ;
            base <= '0;
            wdata <= '0;
            rdata <= '0;
            idx <= '0;
            tries <= '0;
            busy_pins <= 1'b0;
            ce_n <= 1'b1;
            oe_n <= 1'b1;
            pgm_n <= 1'b1;
            drive <= 1'b0;
            addr_q <= '0;
            dout <= '0;
            done_v <= 1'b0;
            fail <= 1'b0;
        end else begin
            state <= next_state;
            op <= next_op;
            base <= next_base;
            wdata <= next_wdata;
            rdata <= next_rdata;
            idx <= next_idx;
            tries <= next_tries;
            busy_pins <= next_busy_pins;
            ce_n <= next_ce_n;
            oe_n <= next_oe_n;
            pgm_n <= next_pgm_n;
            drive <= next_drive;
            addr_q <= next_addr_q;
            dout <= next_dout;
            done_v <= next_done_v;
            fail <= next_fail;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // reset is held low for the whole session so the part stays in prom mode
    assign dev_reset_n = 1'b0;
    assign vpp_high = busy_pins && (op != OP_READ);
    assign chip_enable_n = ce_n;
    assign output_enable_n = oe_n;
    assign program_pulse_n = pgm_n;
    assign prog_address_bus = addr_q;
    assign prog_data_bus_out = dout;
    assign prog_data_bus_oe_n = !drive;
    assign cmd_ready = (state == ST_IDLE);
    assign rsp_valid = done_v;
    assign rsp_fail = fail;
    assign rsp_data = rdata;
    assign rsp_tries = tries;
    // blank check only meaningful on reads
    assign rsp_blank = (lane(rdata, '0) == ERASED);
endmodule // prom_programmer
`default_nettype wire

// File: rtl/prom_prog_pkg.sv
// constants shared by the prom programmer controller
package prom_prog_pkg;
    localparam int ADDR_W = 17;                 // prog_address_bus width
    localparam int DATA_W = 8;                  // prog_data_bus width
    localparam int PAGE_BYTES = 4;              // bytes latched per page
    localparam int PAGE_IDX_W = 2;              // low address bits selecting the byte
    localparam int MAX_TRIES = 10;              // write/verify attempts per unit
    localparam int PULSE_NS = 100000;           // 0.1 ms program pulse
    localparam int CLK_NS = 20;                 // 50 MHz clock period
    localparam int PULSE_CYC = PULSE_NS / CLK_NS;
    localparam int SETUP_CYC = 2;               // settle time around strobes
    localparam int SAMPLE_CYC = 4;              // read access wait (covers sync delay)
    localparam logic [DATA_W-1:0] ERASED = 8'hff;
    typedef enum logic [1:0] {
        OP_READ,
        OP_BYTE,
        OP_PAGE
    } op_t;
endpackage

// File: rtl/strobe_timer.sv
// down counter timing strobe and settle intervals
`timescale 1ns/1ps
`default_nettype none
module strobe_timer
    import prom_prog_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic [CNT_W-1:0] load_val,
    output logic done
);
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;

    // ---------------------------------------------------------------
    // counter
    // ---------------------------------------------------------------
    // load wins over counting so a new interval starts cleanly
    always_comb begin
        next_count = count;
        if (load) begin
            next_count = load_val;
        end else if (count != '0) begin
            next_count = count - CNT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    // done looks at the count only: gating it with load would close a loop
    // through the sequencer, which raises load from done
    assign done = (count == '0);
endmodule // strobe_timer
`default_nettype wire

// File: bench/prom_programmer_checker.sv
// concurrent checks on the prom programmer pins and responses
`timescale 1ns/1ps
`default_nettype none
module prom_programmer_checker
    import prom_prog_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYC,
    parameter int TRIES = MAX_TRIES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic rsp_valid,
    input wire logic rsp_fail,
    input wire logic rsp_blank,
    input wire logic [PAGE_BYTES*DATA_W-1:0] rsp_data,
    input wire logic [3:0] rsp_tries,
    input wire logic dev_reset_n,
    input wire logic chip_enable_n,
    input wire logic output_enable_n,
    input wire logic program_pulse_n,
    input wire logic prog_data_bus_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // pulse length counter: a long repetition would choke the tools
    logic [15:0] low_cnt;
    logic [15:0] next_low_cnt;
    always_comb begin
        next_low_cnt = program_pulse_n ? 16'h0000 : low_cnt + 16'h0001;
    end
    always_ff @(posedge clk) begin
        low_cnt <= sys_rst ? 16'h0000 : next_low_cnt;
    end
    // pin patterns of the verify step and of the pulse end
    sequence s_verify_read;
        !chip_enable_n && !output_enable_n && program_pulse_n;
    endsequence
    sequence s_pulse_end;
        $rose(program_pulse_n);
    endsequence
    a_reset_held: assert property (!dev_reset_n)
        else $error("device reset not held low");
    a_pulse_width: assert property (s_pulse_end |-> low_cnt == 16'(PULSE_CYCLES))
        else $error("program pulse width wrong");
    a_verify_follows: assert property (s_pulse_end |-> ##[1:60] s_verify_read)
        else $error("no verify read after pulse");
    a_latch_strobe: assert property (!output_enable_n && chip_enable_n |->
        program_pulse_n && !prog_data_bus_oe_n)
        else $error("page latch strobe without data");
    a_page_float: assert property (!program_pulse_n && chip_enable_n |->
        output_enable_n && prog_data_bus_oe_n)
        else $error("page pulse with bus driven");
    a_byte_drive: assert property (!program_pulse_n && !chip_enable_n |->
        output_enable_n && !prog_data_bus_oe_n)
        else $error("byte pulse without data");
    a_bus_release: assert property (!chip_enable_n && !output_enable_n |-> prog_data_bus_oe_n)
        else $error("bus contention on read");
    a_fail_tries: assert property (rsp_valid && rsp_fail |-> rsp_tries == 4'(TRIES))
        else $error("failure before all tries");
    a_rsp_single: assert property (rsp_valid |=> !rsp_valid)
        else $error("response longer than a cycle");
    a_blank_flag: assert property (rsp_valid |-> rsp_blank == (rsp_data[7:0] == ERASED))
        else $error("blank flag wrong");
endmodule // prom_programmer_checker
bind prom_programmer prom_programmer_checker #(.PULSE_CYCLES(PULSE_CYCLES), .TRIES(TRIES)) i_chk (
    .clk(clk), .sys_rst(sys_rst), .rsp_valid(rsp_valid), .rsp_fail(rsp_fail),
    .rsp_blank(rsp_blank), .rsp_data(rsp_data), .rsp_tries(rsp_tries),
    .dev_reset_n(dev_reset_n), .chip_enable_n(chip_enable_n),
    .output_enable_n(output_enable_n), .program_pulse_n(program_pulse_n),
    .prog_data_bus_oe_n(prog_data_bus_oe_n));
`default_nettype wire

// File: bench/prom_device_model.sv
// behavioural model of the device side of the programming port
`timescale 1ns/1ps
`default_nettype none
module prom_device_model
    import prom_prog_pkg::*;
#(
    parameter int MIN_PULSE_NS = 400
) (
    input wire logic reset_n,
    input wire logic vpp_high,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic pgm_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] bus,
    output logic [DATA_W-1:0] dq_out
);
    logic [DATA_W-1:0] mem [2**ADDR_W];
    logic [DATA_W-1:0] page [PAGE_BYTES];
    logic [DATA_W-1:0] last = 8'h00;
    logic [DATA_W-1:0] w_data;
    logic [ADDR_W-1:0] w_addr;
    logic w_page, w_ok, dq_en;
    int skip_pulses = 0; // pulses that fail to program, set by the bench
    realtime t_fall;
    // every cell starts erased
    initial begin
        for (int i = 0; i < 2**ADDR_W; i++) mem[i] = ERASED;
    end
    function automatic logic [DATA_W-1:0] rd(input logic [ADDR_W-1:0] a);
        return mem[a];
    endfunction
    // drive only in read or verify; released bus shows the inverse, not a held copy
    assign dq_en = !reset_n && !ce_n && !oe_n && pgm_n;
    assign dq_out = dq_en ? rd(addr) : ~last;
    always @(*) begin
        if (dq_en) last = rd(addr);
    end
    // page latch, lane picked by the two low address bits
    always @(*) begin
        if (!reset_n && ce_n && !oe_n && pgm_n) page[addr[1:0]] = bus;
    end
    // mode captured at the pulse start, since strobes may rise together at its end
    always @(negedge pgm_n) begin
        t_fall = $realtime;
        w_page = ce_n;
        w_ok = !reset_n && vpp_high && oe_n;
        w_addr = addr;
        w_data = bus;
    end
    always @(posedge pgm_n) begin
        if (w_ok === 1'b1 && ($realtime - t_fall) >= MIN_PULSE_NS) begin
            if (skip_pulses > 0) skip_pulses--;
            else if (w_page) for (int i = 0; i < PAGE_BYTES; i++)
                mem[{w_addr[ADDR_W-1:2], 2'(i)}] = page[i];
            else mem[w_addr] = w_data;
        end
    end
endmodule // prom_device_model
`default_nettype wire

// File: bench/prom_programmer_tb.sv
// self-checking testbench of the prom programmer against the device model
`timescale 1ns/1ps
`default_nettype none
module prom_programmer_tb
    import prom_prog_pkg::*;
;
    logic clk = 1'b0, sys_rst = 1'b1, cmd_valid = 1'b0;
    op_t cmd_op = OP_READ;
    logic [ADDR_W-1:0] cmd_addr = 17'h00000;
    logic [31:0] cmd_data = 32'h00000000;
    logic cmd_ready, rsp_valid, rsp_fail, rsp_blank, dev_reset_n, vpp_high;
    logic chip_enable_n, output_enable_n, program_pulse_n, data_oe_n;
    logic [31:0] rsp_data;
    logic [3:0] rsp_tries;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data_out, dev_out;
    wire logic [DATA_W-1:0] bus;
    int n_errors = 0, tests_run = 0, cycles = 0;
    // resolved data wire: whichever side enables its driver
    assign bus = !data_oe_n ? data_out : dev_out;
    prom_programmer #(.PULSE_CYCLES(20)) i_dut (.clk(clk), .sys_rst(sys_rst),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_fail(rsp_fail), .rsp_blank(rsp_blank),
        .rsp_data(rsp_data), .rsp_tries(rsp_tries), .dev_reset_n(dev_reset_n),
        .vpp_high(vpp_high), .chip_enable_n(chip_enable_n), .output_enable_n(output_enable_n),
        .program_pulse_n(program_pulse_n), .prog_address_bus(addr), .prog_data_bus_in(bus),
        .prog_data_bus_out(data_out), .prog_data_bus_oe_n(data_oe_n));
    prom_device_model #(.MIN_PULSE_NS(400)) i_dev (.reset_n(dev_reset_n), .vpp_high(vpp_high),
        .ce_n(chip_enable_n), .oe_n(output_enable_n), .pgm_n(program_pulse_n), .addr(addr),
        .bus(bus), .dq_out(dev_out));
    initial begin
        forever #10 clk = ~clk;
    end
    // hang guard, well above the roughly 1300 cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            $display("mismatch at %0t: timeout", $time);
            complete_run();
        end
    end
    task automatic check_bit(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // one command: hold valid until taken, then wait for the response pulse
    task automatic run_cmd(input op_t op, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        @(negedge clk);
        cmd_op = op;
        cmd_addr = a;
        cmd_data = d;
        cmd_valid = 1'b1;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 100) begin @(negedge clk); n++; end
        @(negedge clk);
        cmd_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 2000) begin @(negedge clk); n++; end
        check_bit(rsp_valid, 1'b1, "response");
    endtask
    task automatic read_expect(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        run_cmd(OP_READ, a, 32'h00000000);
        check_word({24'h000000, rsp_data[7:0]}, {24'h000000, exp}, "read data");
        check_bit(rsp_blank, exp == 8'hff, "blank flag");
    endtask
    task automatic t_reset_pins();
        check_bit(dev_reset_n, 1'b0, "device reset");
        check_bit(chip_enable_n, 1'b1, "chip enable idle");
        check_bit(program_pulse_n, 1'b1, "pulse idle");
        check_bit(data_oe_n, 1'b1, "bus released");
        check_bit(output_enable_n, 1'b1, "oe idle");
        check_bit(vpp_high, 1'b0, "supply low idle");
        $display("test reset_pins done");
    endtask
    task automatic t_blank_read();
        read_expect(17'h00040, 8'hff);
        read_expect(17'h1ffff, 8'hff);
        $display("test blank_read done");
    endtask
    task automatic t_byte_write();
        run_cmd(OP_BYTE, 17'h00123, 32'hdeadbe5a);
        check_bit(rsp_fail, 1'b0, "byte fail");
        check_word({28'h0000000, rsp_tries}, 32'h00000001, "byte tries");
        read_expect(17'h00123, 8'h5a);
        read_expect(17'h00124, 8'hff);
        $display("test byte_write done");
    endtask
    task automatic t_page_write();
        logic [31:0] d;
        d = 32'h44332211;
        run_cmd(OP_PAGE, 17'h00206, d);
        check_bit(rsp_fail, 1'b0, "page fail");
        for (int i = 0; i < 4; i++) read_expect(17'h00204 + 17'(i), d[8*i +: 8]);
        read_expect(17'h00208, 8'hff);
        $display("test page_write done");
    endtask
    task automatic t_retry();
        i_dev.skip_pulses = 2;
        run_cmd(OP_BYTE, 17'h00300, 32'h000000a5);
        check_bit(rsp_fail, 1'b0, "retry fail");
        check_word({28'h0000000, rsp_tries}, 32'h00000003, "retry tries");
        read_expect(17'h00300, 8'ha5);
        $display("test retry done");
    endtask
    task automatic t_give_up();
        i_dev.skip_pulses = 50;
        run_cmd(OP_PAGE, 17'h00400, 32'h12345678);
        check_bit(rsp_fail, 1'b1, "give up fail");
        check_word({28'h0000000, rsp_tries}, 32'h0000000a, "give up tries");
        check_word(32'(i_dev.skip_pulses), 32'h00000028, "pulses issued");
        i_dev.skip_pulses = 0;
        read_expect(17'h00401, 8'hff);
        $display("test give_up done");
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
        t_reset_pins();
        t_blank_read();
        t_byte_write();
        t_page_write();
        t_retry();
        t_give_up();
        complete_run();
    end
endmodule // prom_programmer_tb
`default_nettype wire
